// [rtl/urxe_consts.svh]
// Register offsets, field positions, reset values and timing for the receive error and wake block
// What this block does
// - Receive interrupt when a word enters the buffer or an overrun occurs, if enabled.
// - Four bytes sit in the FIFO while a fifth shifts in; its completion overruns.
// - Overrun sets its flag, keeps FIFO contents, overwrites the shift register.
// - Overrun flag clears only on status access followed by data buffer read.
// - Noise sets the noise flag with data available, data still stored, no own interrupt.
// - Noise flag clears on status read followed by data buffer read.
// - Framing error when any expected stop bit samples low.
// - Framing flag stored with the word; cleared by any reset.
// - Parity mismatch sets parity error when parity is enabled; stored with word.
// - Interrupt request is a low pulse from the five listed sources.
// - Transmit sources have own enables; receive sources share one enable.
// - Status flags are read-only; error and data flags clear only through their access sequences.
// - With address detect on, data-available interrupt needs highest received bit high.
// - With address detect off, every data-available event interrupts.
// - With the port clock stopped, reception pauses and the receiver state and baud divider hold.
// - Clock off plus all wake enables: falling receive edge requests wake-up.
// - Line data ignored during start-up delay; wake interrupt given after it.
// - Wake interrupts only with global, multi-function and port enables; else event only.
// - Each bit is a majority of three samples; disagreement means noise.
`ifndef URXE_CONSTS_SVH
`define URXE_CONSTS_SVH

`define URXE_ADDR_W        8
`define URXE_OFF_CTRL      8'h00
`define URXE_OFF_STATUS    8'h04
`define URXE_OFF_DATA      8'h08
`define URXE_OFF_BAUD      8'h0C

`define URXE_CTRL_W        15
`define URXE_CTRL_RESET    15'h0000
`define URXE_BAUD_RESET    16'h0000

`define URXE_ST_AVAIL      0
`define URXE_ST_OVERRUN    1
`define URXE_ST_NOISE      2
`define URXE_ST_FRAMING    3
`define URXE_ST_PARITY     4
`define URXE_ST_RX_IDLE    5
`define URXE_ST_TX_EMPTY   6
`define URXE_ST_TX_IDLE    7
`define URXE_ST_BIT9       8
`define URXE_ST_COUNT_LO   9

`define URXE_SAMP_A        4'h7
`define URXE_SAMP_B        4'h8
`define URXE_SAMP_C        4'h9
`define URXE_SAMP_LAST     4'hF
`define URXE_LAST_BIT8     4'h7
`define URXE_LAST_BIT9     4'h8

`define URXE_CLK_PERIOD_NS 100
`define URXE_WAKE_DELAY_NS 2000
`define URXE_WAKE_CYCLES   ((`URXE_WAKE_DELAY_NS + `URXE_CLK_PERIOD_NS - 1) / `URXE_CLK_PERIOD_NS)

`endif

// [rtl/urxe_pkg.sv]
// Types shared by the receive error and wake block
package urxe_pkg;

  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} urxe_parity_type;

  typedef struct packed {
    logic            port_irq_enable;
    logic            multifunc_irq_enable;
    logic            global_irq_enable;
    logic            pin_wake_enable;
    logic            two_stop;
    urxe_parity_type parity_type;
    logic            parity_enable;
    logic            nine_bit_select;
    logic            addr_detect_enable;
    logic            tx_idle_irq_enable;
    logic            tx_empty_irq_enable;
    logic            rx_irq_enable;
    logic            receiver_enable;
    logic            port_enable;
  } urxe_ctrl_type;

  typedef struct packed {
    logic       noise;
    logic       framing;
    logic       parity;
    logic [8:0] data;
  } urxe_word_type;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP1, RX_STOP2} urxe_rx_state_type;

endpackage

// [rtl/urxe_top.sv]
// Serial receiver with error flags, four-word FIFO, interrupt pulse and pin wake-up
`timescale 1ns/10ps
`include "urxe_consts.svh"

module urxe_top #(
  parameter int unsigned FIFO_DEPTH  = 4,
  parameter int unsigned WAKE_CYCLES = `URXE_WAKE_CYCLES
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`URXE_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Serial line and port clock state
  input  wire logic                     rx_pin,
  input  wire logic                     uart_clk_on,
  // Transmit path status
  input  wire logic                     tx_empty,
  input  wire logic                     tx_idle,
  // Interrupt and wake
  output logic                          irq_n,
  output logic                          wake_event
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int HW = $clog2(WAKE_CYCLES + 1);
  localparam logic [PW:0]   DEPTH_C = (PW+1)'(FIFO_DEPTH);
  localparam logic [HW-1:0] WAKE_C  = HW'(WAKE_CYCLES);
  localparam logic [HW-1:0] HOLD_ONE = HW'(1);

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Registers
  urxe_pkg::urxe_ctrl_type     ctrl_reg;
  logic [15:0]                 baud_reg;
  logic [15:0]                 div_cnt_reg;
  logic                        rx_meta_reg, rx_sync_reg, rx_prev_reg;
  urxe_pkg::urxe_rx_state_type state_reg, state_next;
  logic [3:0]                  samp_reg, samp_next;
  logic [2:0]                  votes_reg, votes_next;
  logic [3:0]                  bitn_reg, bitn_next;
  logic [8:0]                  rx_shift_reg, rx_shift_next;
  logic                        par_reg, par_next;
  logic                        fe_reg, fe_next;
  logic                        nacc_reg, nacc_next;
  logic                        done_reg, done_next;
  urxe_pkg::urxe_word_type     mem [FIFO_DEPTH];
  logic [PW-1:0]               wr_ptr_reg, rd_ptr_reg;
  logic [PW:0]                 count_reg;
  urxe_pkg::urxe_word_type     hold_reg;
  logic                        hold_valid_reg;
  logic                        overrun_flag, noise_flag, seen_reg;
  logic                        rd_ok_reg;
  logic [31:0]                 prdata_reg;
  logic                        irq_pulse_reg, wake_event_reg, wake_pend_reg;
  logic [HW-1:0]               hold_cnt_reg;
  logic                        txe_prev_reg, txi_prev_reg;

  // APB decode
  wire acc      = psel & penable;
  wire sel_ctrl = (paddr == `URXE_OFF_CTRL);
  wire sel_stat = (paddr == `URXE_OFF_STATUS);
  wire sel_data = (paddr == `URXE_OFF_DATA);
  wire sel_baud = (paddr == `URXE_OFF_BAUD);
  wire mapped   = sel_ctrl | sel_stat | sel_data | sel_baud;
  wire wr_ctrl  = acc & pwrite & sel_ctrl;
  wire wr_baud  = acc & pwrite & sel_baud;
  wire stat_acc = acc & sel_stat;
  wire data_rd  = acc & ~pwrite & sel_data;
  wire setup_rd = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_reg;

  // Receive timing and line sampling
  wire tick      = uart_clk_on & (div_cnt_reg == baud_reg);
  wire bit_end   = tick & (samp_reg == `URXE_SAMP_LAST);
  wire vote      = maj3(votes_reg);
  wire vote_bad  = ~((votes_reg[0] == votes_reg[1]) & (votes_reg[1] == votes_reg[2]));
  wire in_window = (samp_reg == `URXE_SAMP_A) | (samp_reg == `URXE_SAMP_B) | (samp_reg == `URXE_SAMP_C);
  wire rx_run    = ctrl_reg.port_enable & ctrl_reg.receiver_enable & (hold_cnt_reg == '0);
  wire [3:0] last_bit = ctrl_reg.nine_bit_select ? `URXE_LAST_BIT9 : `URXE_LAST_BIT8;

  // Receiver state machine next values
  always_comb begin
    state_next    = state_reg;
    samp_next     = samp_reg;
    votes_next    = votes_reg;
    bitn_next     = bitn_reg;
    rx_shift_next = rx_shift_reg;
    par_next      = par_reg;
    fe_next       = fe_reg;
    nacc_next     = nacc_reg;
    done_next     = 1'b0;
    if (!rx_run) begin
      // Clearing the receiver enable abandons the frame
      state_next = urxe_pkg::RX_IDLE;
      samp_next  = '0;
    end else if (tick) begin
      samp_next = samp_reg + 4'h1;
      if (in_window) begin
        votes_next = {votes_reg[1:0], rx_sync_reg};
      end
      if (bit_end && state_reg != urxe_pkg::RX_IDLE) begin
        nacc_next = nacc_reg | vote_bad;
      end
      case (state_reg)
        urxe_pkg::RX_IDLE: begin
          samp_next = '0;
          if (!rx_sync_reg) begin
            state_next = urxe_pkg::RX_START;
            samp_next  = 4'h1;
            nacc_next  = 1'b0;
            fe_next    = 1'b0;
            par_next   = 1'b0;
          end
        end
        urxe_pkg::RX_START: begin
          if (bit_end) begin
            state_next = vote ? urxe_pkg::RX_IDLE : urxe_pkg::RX_DATA;
            bitn_next  = '0;
          end
        end
        urxe_pkg::RX_DATA: begin
          if (bit_end) begin
            rx_shift_next = {vote, rx_shift_reg[8:1]};
            bitn_next     = bitn_reg + 4'h1;
            if (bitn_reg == last_bit) begin
              state_next = ctrl_reg.parity_enable ? urxe_pkg::RX_PARITY : urxe_pkg::RX_STOP1;
            end
          end
        end
        urxe_pkg::RX_PARITY: begin
          if (bit_end) begin
            par_next   = vote;
            state_next = urxe_pkg::RX_STOP1;
          end
        end
        urxe_pkg::RX_STOP1: begin
          if (bit_end) begin
            fe_next    = ~vote;
            state_next = ctrl_reg.two_stop ? urxe_pkg::RX_STOP2 : urxe_pkg::RX_IDLE;
            done_next  = ~ctrl_reg.two_stop;
          end
        end
        urxe_pkg::RX_STOP2: begin
          if (bit_end) begin
            fe_next    = fe_reg | ~vote;
            state_next = urxe_pkg::RX_IDLE;
            done_next  = 1'b1;
          end
        end
        default: state_next = urxe_pkg::RX_IDLE;
      endcase
    end
  end

  // Completed word with its error marks
  wire [8:0] data9 = ctrl_reg.nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  logic par_exp;
  always_comb begin
    case (ctrl_reg.parity_type)
      urxe_pkg::PAR_EVEN:  par_exp = ^data9;
      urxe_pkg::PAR_ODD:   par_exp = ~^data9;
      urxe_pkg::PAR_MARK:  par_exp = 1'b1;
      urxe_pkg::PAR_SPACE: par_exp = 1'b0;
      default:             par_exp = 1'b0;
    endcase
  end
  urxe_pkg::urxe_word_type new_word;
  // Error marks travel with the stored word
  assign new_word = '{noise: nacc_reg, framing: fe_reg,
                      parity: ctrl_reg.parity_enable & (par_reg != par_exp), data: data9};

  // FIFO and shift holding slot
  urxe_pkg::urxe_word_type head, push_word;
  assign head = mem[rd_ptr_reg];
  wire pop      = data_rd & rd_ok_reg & (count_reg != '0);
  wire full_eff = (count_reg == DEPTH_C) & ~pop;
  wire mv       = pop & hold_valid_reg;
  // Fifth word waits in the shift register; completing it with the FIFO full overruns
  wire push     = mv | (done_reg & ~full_eff);
  // Overrun leaves the FIFO alone and overwrites the shift slot
  wire ovr_set  = done_reg & ~mv & full_eff;
  assign push_word = mv ? hold_reg : new_word;
  wire clr_seq  = data_rd & seen_reg;
  wire addr_bit = ctrl_reg.nine_bit_select ? push_word.data[8] : push_word.data[7];

  // Interrupt sources
  wire gate       = ctrl_reg.global_irq_enable & ctrl_reg.multifunc_irq_enable & ctrl_reg.port_irq_enable;
  // Data available, qualified by address detect
  wire avail_evt  = push & ctrl_reg.rx_irq_enable & (~ctrl_reg.addr_detect_enable | addr_bit);
  wire ovr_evt    = ovr_set & ctrl_reg.rx_irq_enable;
  // Transmit sources each with own enable
  wire txe_evt    = tx_empty & ~txe_prev_reg & ctrl_reg.tx_empty_irq_enable;
  wire txi_evt    = tx_idle & ~txi_prev_reg & ctrl_reg.tx_idle_irq_enable;
  // Wake interrupt only once the start-up delay ends
  wire wake_fire  = uart_clk_on & (hold_cnt_reg == HOLD_ONE);
  wire any_evt    = avail_evt | ovr_evt | txe_evt | txi_evt | wake_fire;
  // Wake arming with the port clock off
  wire wake_arm   = ~uart_clk_on & ctrl_reg.pin_wake_enable & ctrl_reg.port_enable &
                    ctrl_reg.receiver_enable & ctrl_reg.rx_irq_enable;
  wire rx_fall    = rx_prev_reg & ~rx_sync_reg;

  // Status word
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[`URXE_ST_AVAIL]    = count_reg != '0;
    status_word[`URXE_ST_OVERRUN]  = overrun_flag;
    status_word[`URXE_ST_NOISE]    = noise_flag;
    status_word[`URXE_ST_FRAMING]  = (count_reg != '0) & head.framing;
    status_word[`URXE_ST_PARITY]   = (count_reg != '0) & head.parity;
    status_word[`URXE_ST_RX_IDLE]  = state_reg == urxe_pkg::RX_IDLE;
    status_word[`URXE_ST_TX_EMPTY] = tx_empty;
    status_word[`URXE_ST_TX_IDLE]  = tx_idle;
    status_word[`URXE_ST_BIT9]     = head.data[8];
    status_word[`URXE_ST_COUNT_LO +: PW+1] = count_reg;
  end
  wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_reg) : sel_baud ? {16'h0000, baud_reg} :
                       sel_stat ? status_word : (sel_data && count_reg != '0) ? 32'(head.data) : 32'h0000_0000;

  // APB registers and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= urxe_pkg::urxe_ctrl_type'(`URXE_CTRL_RESET);
      baud_reg   <= `URXE_BAUD_RESET;
      prdata_reg <= 32'h0000_0000;
      rd_ok_reg  <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= urxe_pkg::urxe_ctrl_type'(pwdata[`URXE_CTRL_W-1:0]);
      if (wr_baud) baud_reg <= pwdata[15:0];
      if (setup_rd) begin
        prdata_reg <= rd_mux;
        rd_ok_reg  <= sel_data & (count_reg != '0);
      end
    end
  end

  // Line synchroniser and baud divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      div_cnt_reg <= 16'h0000;
    end else begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
      if (tick) div_cnt_reg <= 16'h0000;
      else if (uart_clk_on) div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // Receiver state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= urxe_pkg::RX_IDLE;
      samp_reg     <= '0;
      votes_reg    <= 3'h7;
      bitn_reg     <= '0;
      rx_shift_reg <= '0;
      par_reg      <= 1'b0;
      fe_reg       <= 1'b0;
      nacc_reg     <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      samp_reg     <= samp_next;
      votes_reg    <= votes_next;
      bitn_reg     <= bitn_next;
      rx_shift_reg <= rx_shift_next;
      par_reg      <= par_next;
      fe_reg       <= fe_next;
      nacc_reg     <= nacc_next;
      done_reg     <= done_next;
    end
  end

  // FIFO storage
  always_ff @(posedge pclk) begin
    if (push) mem[wr_ptr_reg] <= push_word;
  end

  // FIFO pointers, holding slot and sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg     <= '0;
      rd_ptr_reg     <= '0;
      count_reg      <= '0;
      hold_reg       <= '0;
      hold_valid_reg <= 1'b0;
      overrun_flag   <= 1'b0;
      noise_flag     <= 1'b0;
      seen_reg       <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)  rd_ptr_reg <= rd_ptr_reg + PW'(1);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      if (done_reg && (mv || full_eff)) begin
        hold_reg       <= new_word;
        hold_valid_reg <= 1'b1;
      end else if (mv) begin
        hold_valid_reg <= 1'b0;
      end
      // Set wins over the status-then-data clear
      overrun_flag <= ovr_set | (overrun_flag & ~clr_seq);
      // Noise rises with data available; same clear sequence
      noise_flag   <= (push & push_word.noise) | (noise_flag & ~clr_seq);
      seen_reg     <= stat_acc | (seen_reg & ~data_rd);
    end
  end

  // Wake-up, start-up hold and interrupt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_reg <= 1'b0;
      wake_pend_reg  <= 1'b0;
      hold_cnt_reg   <= '0;
      irq_pulse_reg  <= 1'b0;
      txe_prev_reg   <= 1'b0;
      txi_prev_reg   <= 1'b0;
    end else begin
      // Wake event pulse whatever the global, multi-function and port enables
      wake_event_reg <= wake_arm & rx_fall;
      if (wake_arm && rx_fall) wake_pend_reg <= 1'b1;
      else if (uart_clk_on) wake_pend_reg <= 1'b0;
      // Receiver held off for the start-up delay
      if (uart_clk_on && wake_pend_reg) hold_cnt_reg <= WAKE_C;
      else if (uart_clk_on && hold_cnt_reg != '0) hold_cnt_reg <= hold_cnt_reg - HOLD_ONE;
      // One-cycle low pulse for each cycle holding a qualifying event
      irq_pulse_reg <= gate & any_evt;
      txe_prev_reg  <= tx_empty;
      txi_prev_reg  <= tx_idle;
    end
  end
  assign irq_n      = ~irq_pulse_reg;
  assign wake_event = wake_event_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rx_word_irq: assert property (avail_evt && gate |=> !irq_n) else $error("word stored without irq pulse");
  a_fifo_bound: assert property (count_reg <= DEPTH_C && (!hold_valid_reg || count_reg == DEPTH_C))
    else $error("fifo count out of range");
  a_overrun_keep: assert property (ovr_set |=> overrun_flag && count_reg == $past(count_reg) && hold_valid_reg)
    else $error("overrun disturbed fifo");
  a_overrun_clear: assert property ($fell(overrun_flag) |-> $past(data_rd && seen_reg))
    else $error("overrun cleared without sequence");
  a_noise_rise: assert property ($rose(noise_flag) |-> $past(push)) else $error("noise flag without stored word");
  a_noise_clear: assert property ($fell(noise_flag) |-> $past(data_rd && seen_reg))
    else $error("noise cleared without sequence");
  a_stop_low: assert property (state_reg == urxe_pkg::RX_STOP1 && bit_end && rx_run && !vote |=> fe_reg)
    else $error("low stop bit not flagged");
  a_addr_filter: assert property (ctrl_reg.addr_detect_enable && push && !addr_bit |-> !avail_evt)
    else $error("address detect not filtering");
  a_pause_hold: assert property (!uart_clk_on |=> state_reg == $past(state_reg) && samp_reg == $past(samp_reg))
    else $error("receiver moved with clock off");
  a_wake_ignore: assert property (hold_cnt_reg != '0 |=> state_reg == urxe_pkg::RX_IDLE)
    else $error("line data taken during start-up");
  a_irq_single: assert property (!irq_n |-> $past(gate && any_evt)) else $error("irq pulse without event");

  c_overrun: cover property (ovr_set);
  c_wake_irq: cover property (wake_fire && gate);
  c_framing_word: cover property (push && push_word.framing);
  c_noise_word: cover property (push && push_word.noise);

endmodule

// [dv/urxe_line_model.sv]
// Remote serial transmitter driving the receive line
`timescale 1ns/10ps
module urxe_line_model (
  // Clock
  input  wire logic pclk,
  // Serial line, idle high
  output logic      rx_pin
);
  initial rx_pin = 1'b1;

  // Sends n bits LSB first at 16 clocks a bit, with an optional one-clock glitch
  // The glitch sits on the middle one of the three voting samples, after the two-stage line sync
  task automatic send(input logic [11:0] bits, input int n, input int glitch);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge pclk);
        rx_pin <= (i == glitch && c == 8) ? ~bits[i] : bits[i];
      end
    end
    @(posedge pclk);
    rx_pin <= 1'b1;
  endtask
endmodule

// [dv/tb_urxe_top.sv]
// Self-checking bench for the receive error and wake block
`timescale 1ns/10ps
`include "urxe_consts.svh"
module tb_urxe_top;
  localparam int WC = 3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_pin, uart_clk_on, tx_empty, tx_idle, irq_n, wake_event, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          err_total = 0;
  int          comparisons = 0;
  int          irqs = 0;
  int          wakes = 0;
  logic [7:0]  exp_q[5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h15};

  urxe_top #(.FIFO_DEPTH(4), .WAKE_CYCLES(WC)) i_urxe_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .uart_clk_on(uart_clk_on), .tx_empty(tx_empty), .tx_idle(tx_idle),
    .irq_n(irq_n), .wake_event(wake_event));
  urxe_line_model i_urxe_line_model (.pclk(pclk), .rx_pin(rx_pin));

  // Clock at 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Counts interrupt low cycles and wake pulses
  always @(posedge pclk) begin
    if (irq_n === 1'b0) irqs++;
    if (wake_event === 1'b1) wakes++;
  end

  task automatic print_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      err_total++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0000_0000, r, x);
    chk(s, r & m, e);
  endtask

  task automatic rx(input logic [11:0] b, input int n, input int g);
    i_urxe_line_model.send(b, n, g);
    repeat (40) @(posedge pclk);
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, presetn, tx_empty, tx_idle} = 6'b00_0000;
    {paddr, pwdata} = 40'h00_0000_0000;
    uart_clk_on = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`URXE_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl reset");
    rd(`URXE_OFF_BAUD, 32'hFFFF_FFFF, 32'h0000_0000, "baud reset");
    apb(1'b0, 8'h10, 32'h0000_0000, q, er);
    chk("unmapped err", {31'h0000_0000, er}, 32'h0000_0001);
    wr(`URXE_OFF_CTRL, 32'h0000_7007);
    wr(`URXE_OFF_STATUS, 32'h0000_FFFF);
    rd(`URXE_OFF_STATUS, 32'h0000_001F, 32'h0000_0000, "status ro");
    rx({3'b111, 8'hA5, 1'b0}, 10, -1);
    chk("irq one word", irqs, 1);
    rd(`URXE_OFF_STATUS, 32'h0000_0E01, 32'h0000_0201, "avail");
    rd(`URXE_OFF_DATA, 32'h0000_01FF, 32'h0000_00A5, "data a5");
    wr(`URXE_OFF_CTRL, 32'h0000_7407);
    rx({1'b1, 1'b0, 1'b1, 8'h3C, 1'b0}, 11, -1);
    // Flags read before the data word
    rd(`URXE_OFF_STATUS, 32'h0000_0008, 32'h0000_0008, "framing");
    rd(`URXE_OFF_DATA, 32'h0000_01FF, 32'h0000_003C, "data framed");
    // Parity bit is wrong for every type with one data bit set
    for (int t = 0; t < 4; t++) begin
      wr(`URXE_OFF_CTRL, 32'h0000_7087 | (t << 8));
      rx({2'b11, t[0], 8'h01, 1'b0}, 11, -1);
      rd(`URXE_OFF_STATUS, 32'h0000_0010, 32'h0000_0010, "parity");
      rd(`URXE_OFF_DATA, 32'h0000_01FF, 32'h0000_0001, "data parity");
    end
    chk("irq errors", irqs, 6);
    wr(`URXE_OFF_CTRL, 32'h0000_7007);
    rx({3'b111, 8'h55, 1'b0}, 10, 3);
    rd(`URXE_OFF_STATUS, 32'h0000_0005, 32'h0000_0005, "noise");
    chk("irq noise", irqs, 7);
    rd(`URXE_OFF_DATA, 32'h0000_01FF, 32'h0000_0055, "data noisy");
    rd(`URXE_OFF_STATUS, 32'h0000_0004, 32'h0000_0000, "noise clr");
    wr(`URXE_OFF_CTRL, 32'h0000_7027);
    rx({3'b111, 8'h12, 1'b0}, 10, -1);
    chk("addr low", irqs, 7);
    rx({3'b111, 8'h92, 1'b0}, 10, -1);
    chk("addr high", irqs, 8);
    rd(`URXE_OFF_DATA, 32'h0000_01FF, 32'h0000_0012, "addr d0");
    rd(`URXE_OFF_DATA, 32'h0000_01FF, 32'h0000_0092, "addr d1");
    wr(`URXE_OFF_CTRL, 32'h0000_700F);
    tx_empty <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("tx empty irq", irqs, 9);
    tx_idle <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("tx idle masked", irqs, 9);
    tx_empty <= 1'b0;
    tx_idle <= 1'b0;
    // Wake with and without the three interrupt enables
    for (int i = 0; i < 2; i++) begin
      wr(`URXE_OFF_CTRL, i ? 32'h0000_7807 : 32'h0000_0807);
      uart_clk_on <= 1'b0;
      i_urxe_line_model.send({3'b111, 8'h00, 1'b0}, 10, -1);
      uart_clk_on <= 1'b1;
      repeat (WC + 20) @(posedge pclk);
      chk("wake event", wakes, i + 1);
      chk("wake irq", irqs, 9 + i);
      rd(`URXE_OFF_STATUS, 32'h0000_0E00, 32'h0000_0000, "line ignored");
      rd(`URXE_OFF_CTRL, 32'h0000_FFFF, i ? 32'h0000_7807 : 32'h0000_0807, "ctrl kept");
    end
    wr(`URXE_OFF_CTRL, 32'h0000_7005);
    rx({3'b111, 8'h77, 1'b0}, 10, -1);
    rd(`URXE_OFF_STATUS, 32'h0000_0E01, 32'h0000_0000, "rx suspended");
    chk("irq suspended", irqs, 10);
    wr(`URXE_OFF_CTRL, 32'h0000_7007);
    for (int k = 0; k < 5; k++) rx({3'b111, 8'(8'h10 + k), 1'b0}, 10, -1);
    chk("irq overrun", irqs, 15);
    rd(`URXE_OFF_STATUS, 32'h0000_0E03, 32'h0000_0803, "overrun");
    rx({3'b111, 8'h15, 1'b0}, 10, -1);
    rd(`URXE_OFF_DATA, 32'h0000_01FF, {24'h00_0000, exp_q[0]}, "ovr data");
    rd(`URXE_OFF_STATUS, 32'h0000_0002, 32'h0000_0000, "overrun clr");
    // Remaining four pending words drained after overrun
    for (int k = 1; k < 5; k++) rd(`URXE_OFF_DATA, 32'h0000_01FF, {24'h00_0000, exp_q[k]}, "ovr data");
    print_verdict();
  end
endmodule
